// *** rsf_cfg.svh ***
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
// Summary of operation
// - Popping an empty stack sets the stack underflow flag.
// - Overflow reset enabled: full or underflow sets its flag, then resets the device.
// - Overflow reset disabled: full or underflow sets its flag, no device reset.
// - Full and underflow flags clear only by software write or power-on reset.
// - Overflow reset enable comes from configuration storage, not a runtime register.
// - One-level shadows of status, working and bank select; no software access.
// - Any interrupt vectoring copies status, working and bank select into shadows.
// - Fast return from interrupt reloads the three registers from shadows and pops.
// - High-priority interrupt overwrites low-priority shadows; shadows do not nest.
// - Fast call saves the three registers into shadows while pushing.
// - Fast return from subroutine restores the three registers while popping.
// - Table access uses pointer as byte address, latch as data, one byte each.
// - Push increments 5-bit pointer then writes; pop reads then decrements; reset zeroes.
// - Overflow reset enabled: 31st push stores, sets full, resets, pointer zero.
// - Overflow reset disabled: pointer reaches 31; further pushes neither write nor move.
// - Pop from empty returns zero, sets underflow, pointer stays zero.

`define RSF_SP_EMPTY 5'h00
`define RSF_SP_LAST 5'h1E
`define RSF_SP_TOP 5'h1F
`define RSF_SP_STEP 5'h01
`define RSF_FULL_BIT 7
`define RSF_UNF_BIT 6
`define RSF_EVT_FULL 0
`define RSF_EVT_UNF 1
`define RSF_A_SP 4'h0
`define RSF_A_IST 4'h1
`define RSF_A_IMSK 4'h2
`define RSF_A_TPL 4'h3
`define RSF_A_TPH 4'h4
`define RSF_A_TPU 4'h5
`define RSF_A_TLAT 4'h6
`define RSF_RST_BYTE 8'h00
`define RSF_RST_EVT 2'h0
`define RSF_RST_TPTR 22'h000000
`endif

// *** rsf_core_model.sv ***
`timescale 1ns/10ps
module rsf_core_model import rsf_pkg::*; (
    input wire logic clock_i,
    input wire logic mem_rd_i,
    input wire logic [21:0] tbl_ptr_i,
    output logic push_o,
    output logic vector_o,
    output logic pop_o,
    output logic fast_o,
    output logic [20:0] push_addr_o,
    output rsf_ctx_t ctx_o,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] junk_ff;

    initial begin
        push_o = 1'b0;
        vector_o = 1'b0;
        pop_o = 1'b0;
        fast_o = 1'b0;
        push_addr_o = 21'h000000;
        ctx_o = 24'h000000;
        junk_ff = 8'h5A;
    end

    // Undriven memory bus toggles so a stale byte never looks valid
    always @(posedge clock_i) begin
        junk_ff <= ~junk_ff;
    end

    assign mem_rdata_o = mem_rd_i ? (tbl_ptr_i[7:0] ^ 8'hA5) : junk_ff;

    // One sequencer event per call; the bench relies on the one-cycle result after it
    // A low handler under a high one returns without the fast option
    task automatic op(input logic psh, input logic vec, input logic pp, input logic fst,
                      input logic [20:0] addr, input rsf_ctx_t ctx);
        @(posedge clock_i);
        push_o <= psh;
        vector_o <= vec;
        pop_o <= pp;
        fast_o <= fst;
        push_addr_o <= {addr[20:1], 1'b0};
        ctx_o <= ctx;
        @(posedge clock_i);
        push_o <= 1'b0;
        vector_o <= 1'b0;
        pop_o <= 1'b0;
        fast_o <= 1'b0;
        push_addr_o <= ~addr;
        ctx_o <= ~ctx;
        #1;
    endtask
endmodule

// *** rsf_pkg.sv ***
package rsf_pkg;
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working_register;
        logic [7:0] bank_select_register;
    } rsf_ctx_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsf_bus_t;

    typedef enum logic [0:0] {
        RSF_TBL_IDLE = 1'b0,
        RSF_TBL_WAIT = 1'b1
    } rsf_tbl_state_t;
endpackage

// *** rsf_shadow.sv ***
`timescale 1ns/10ps
`include "rsf_cfg.svh"
module rsf_shadow import rsf_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic save_i,
    input wire rsf_ctx_t ctx_i,
    input wire logic restore_i,
    output rsf_ctx_t ctx_o,
    output logic restore_o
);
    // No bus path reaches this copy; only the core events touch it
    rsf_ctx_t shadow_ff;
    rsf_ctx_t ctx_ff;
    logic restore_ff;

    // Latest save always overwrites; a single level by design
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shadow_ff <= '0;
            ctx_ff <= '0;
            restore_ff <= 1'b0;
        end else begin
            if (save_i) begin
                shadow_ff <= ctx_i;
            end
            if (restore_i) begin
                ctx_ff <= shadow_ff;
            end
            restore_ff <= restore_i;
        end
    end

    assign ctx_o = ctx_ff;
    assign restore_o = restore_ff;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_shadow_save: assert property (save_i ##1 !save_i ##1 restore_i |=>
        ctx_o == $past(ctx_i, 3))
        else $error("restore did not return the latest saved context");
    a_fast_restore: assert property (restore_i |=> restore_o && ctx_o == $past(shadow_ff))
        else $error("fast restore missing or wrong");
endmodule

// *** rsf_stack.sv ***
`timescale 1ns/10ps
`include "rsf_cfg.svh"
module rsf_stack import rsf_pkg::*; #(
    parameter int PC_W = 21
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic dev_rst_i,
    input wire logic cfg_ovf_rst_en_i,
    input wire logic push_i,
    input wire logic vector_i,
    input wire logic pop_i,
    input wire logic fast_i,
    input wire logic [PC_W-1:0] push_addr_i,
    input wire rsf_ctx_t ctx_i,
    input wire logic tbl_rd_i,
    input wire logic tbl_wr_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [PC_W-1:0] pop_addr_o,
    output logic pop_valid_o,
    output rsf_ctx_t ctx_o,
    output logic restore_o,
    output logic stack_reset_o,
    output logic [21:0] tbl_ptr_o,
    output logic [7:0] tbl_lat_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic irq_o
);
    rsf_bus_t bus;
    logic [4:0] sp_ff;
    logic [4:0] nxt_sp;
    logic full_ff;
    logic unf_ff;
    logic [1:0] ist_ff;
    logic [1:0] imsk_ff;
    logic irq_ff;
    logic [7:0] rdata_ff;
    logic [PC_W-1:0] pop_addr_ff;
    logic pop_valid_ff;
    logic stack_reset_ff;
    logic [PC_W-1:0] stack_mem [1:31];
    logic [7:0] read_mux;

    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // Register write decode, shared by the pointer, status and mask offsets
    function automatic logic reg_hit(input rsf_bus_t b, input logic [3:0] a);
        return b.wr && b.addr == a;
    endfunction

    // Events are dropped while another reset holds the core
    wire logic do_push = (push_i || vector_i) && !dev_rst_i;
    wire logic do_pop = pop_i && !push_i && !vector_i && !dev_rst_i;
    wire logic at_empty = sp_ff == `RSF_SP_EMPTY;
    wire logic at_top = sp_ff == `RSF_SP_TOP;
    wire logic stored_push = do_push && !at_top;
    // Slot comes from the old pointer, so a push that also resets still lands
    wire logic [4:0] push_slot = sp_ff + `RSF_SP_STEP;
    wire logic full_evt = do_push && sp_ff == `RSF_SP_LAST;
    wire logic unf_evt = do_pop && at_empty;
    wire logic good_pop = do_pop && !at_empty;
    // Enable is a configuration fuse level, never a bus register
    wire logic ovf_hit = cfg_ovf_rst_en_i && (full_evt || unf_evt);
    wire logic sp_wr = reg_hit(bus, `RSF_A_SP);
    wire logic ist_wr = reg_hit(bus, `RSF_A_IST);
    wire logic imsk_wr = reg_hit(bus, `RSF_A_IMSK);
    wire logic full_clr = sp_wr && !bus.wdata[`RSF_FULL_BIT];
    wire logic unf_clr = sp_wr && !bus.wdata[`RSF_UNF_BIT];
    wire logic [1:0] evt_vec = {unf_evt, full_evt};
    wire logic save_ctx = (vector_i || (push_i && fast_i)) && !dev_rst_i;
    wire logic restore_ctx = good_pop && fast_i;

    // Hardware pointer moves take priority over a software write in the same cycle
    always_comb begin
        if (dev_rst_i || ovf_hit) begin
            nxt_sp = `RSF_SP_EMPTY;
        end else if (stored_push) begin
            nxt_sp = push_slot;
        end else if (good_pop) begin
            nxt_sp = sp_ff - `RSF_SP_STEP;
        end else if (do_push || do_pop) begin
            nxt_sp = sp_ff;
        end else if (sp_wr) begin
            nxt_sp = bus.wdata[4:0];
        end else begin
            nxt_sp = sp_ff;
        end
    end

    // Bit 5 is not implemented and reads as zero
    always_comb begin
        case (bus.addr)
            `RSF_A_SP: read_mux = {full_ff, unf_ff, 1'b0, sp_ff};
            `RSF_A_IST: read_mux = {6'h00, ist_ff};
            `RSF_A_IMSK: read_mux = {6'h00, imsk_ff};
            `RSF_A_TPL: read_mux = tbl_ptr_o[7:0];
            `RSF_A_TPH: read_mux = tbl_ptr_o[15:8];
            `RSF_A_TPU: read_mux = {2'h0, tbl_ptr_o[21:16]};
            `RSF_A_TLAT: read_mux = tbl_lat_o;
            default: read_mux = `RSF_RST_BYTE;
        endcase
    end

    // No location zero; a push at the top never overwrites entry 31
    always_ff @(posedge clock_i) begin
        if (stored_push) begin
            stack_mem[push_slot] <= push_addr_i;
        end
    end

    // Only the power-on reset or a software write clears the flags; dev_rst_i leaves them
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp_ff <= `RSF_SP_EMPTY;
            full_ff <= 1'b0;
            unf_ff <= 1'b0;
        end else begin
            sp_ff <= nxt_sp;
            full_ff <= full_evt || (full_ff && !full_clr);
            unf_ff <= unf_evt || (unf_ff && !unf_clr);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pop_addr_ff <= '0;
            pop_valid_ff <= 1'b0;
            stack_reset_ff <= 1'b0;
        end else begin
            pop_valid_ff <= do_pop;
            pop_addr_ff <= at_empty ? '0 : stack_mem[sp_ff];
            stack_reset_ff <= ovf_hit;
        end
    end

    // Sticky events, set wins over the write-one clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ist_ff <= `RSF_RST_EVT;
            imsk_ff <= `RSF_RST_EVT;
            irq_ff <= 1'b0;
            rdata_ff <= `RSF_RST_BYTE;
        end else begin
            ist_ff <= evt_vec | (ist_ff & ~(ist_wr ? bus.wdata[1:0] : 2'h0));
            if (imsk_wr) imsk_ff <= bus.wdata[1:0];
            irq_ff <= |(ist_ff & imsk_ff);
            rdata_ff <= bus.rd ? read_mux : `RSF_RST_BYTE;
        end
    end

    rsf_shadow u_shadow (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .save_i(save_ctx),
        .ctx_i(ctx_i),
        .restore_i(restore_ctx),
        .ctx_o(ctx_o),
        .restore_o(restore_o)
    );

    rsf_table u_table (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .bus_i(bus),
        .tbl_rd_i(tbl_rd_i),
        .tbl_wr_i(tbl_wr_i),
        .mem_rdata_i(mem_rdata_i),
        .tbl_ptr_o(tbl_ptr_o),
        .tbl_lat_o(tbl_lat_o),
        .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o)
    );

    assign reg_rdata_o = rdata_ff;
    assign pop_addr_o = pop_addr_ff;
    assign pop_valid_o = pop_valid_ff;
    assign stack_reset_o = stack_reset_ff;
    assign irq_o = irq_ff;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_unf_flag_set: assert property (unf_evt |=> unf_ff && sp_ff == `RSF_SP_EMPTY)
        else $error("underflow flag not set or pointer moved");
    a_ovf_reset_fires: assert property (full_evt && cfg_ovf_rst_en_i |=>
        stack_reset_o && full_ff && sp_ff == `RSF_SP_EMPTY)
        else $error("full with reset enabled did not reset");
    a_no_reset_off: assert property (!cfg_ovf_rst_en_i |=> !stack_reset_o)
        else $error("device reset while overflow reset disabled");
    a_flags_hold: assert property (full_ff && !full_clr |=> full_ff)
        else $error("full flag cleared without software write");
    a_push_incr: assert property (stored_push && !full_evt |=>
        sp_ff == $past(sp_ff) + `RSF_SP_STEP && stack_mem[sp_ff] == $past(push_addr_i))
        else $error("push did not increment then store");
    a_full_stays: assert property (!cfg_ovf_rst_en_i && full_evt
        ##1 !(sp_wr || do_pop || dev_rst_i) ##1 do_push |=>
        sp_ff == `RSF_SP_TOP && stack_mem[`RSF_SP_TOP] == $past(push_addr_i, 3))
        else $error("push beyond the top moved pointer or overwrote");
    a_pop_zero: assert property (unf_evt |=> pop_valid_o && pop_addr_o == '0)
        else $error("empty pop did not return zero");
    a_bit5_zero: assert property (bus.rd && bus.addr == `RSF_A_SP |=>
        !reg_rdata_o[5] && reg_rdata_o[4:0] == $past(sp_ff))
        else $error("pointer register read wrong");
    a_vector_save: assert property (vector_i && !dev_rst_i |=>
        u_shadow.shadow_ff == $past(ctx_i))
        else $error("vectoring did not save context");
    a_fast_call_save: assert property (push_i && fast_i && !dev_rst_i |=>
        u_shadow.shadow_ff == $past(ctx_i))
        else $error("fast call did not save context");
    a_fast_pop_restore: assert property (good_pop && fast_i |=> restore_o && pop_valid_o)
        else $error("fast return did not restore while popping");
    a_unf_reset: assert property (unf_evt && cfg_ovf_rst_en_i |=> stack_reset_o && unf_ff)
        else $error("underflow with reset enabled did not reset");
    a_flag_no_reset: assert property (!cfg_ovf_rst_en_i && (full_evt || unf_evt) |=>
        !stack_reset_o && (full_ff || unf_ff))
        else $error("event with reset disabled lost its flag or reset");
    a_top_store: assert property (full_evt |=> stack_mem[`RSF_SP_TOP] == $past(push_addr_i))
        else $error("thirty-first push did not store its address");
    a_unf_hold: assert property (unf_ff && !unf_clr |=> unf_ff)
        else $error("underflow flag cleared without software write");

    c_full_reset: cover property (full_evt && cfg_ovf_rst_en_i ##1 stack_reset_o);
    c_underflow: cover property (unf_evt ##[1:4] irq_o);
    c_fast_call: cover property ((push_i && fast_i) ##[1:8] (pop_i && fast_i));
    c_fast_pair: cover property (vector_i ##[1:20] (pop_i && fast_i));
endmodule

// *** rsf_table.sv ***
`timescale 1ns/10ps
`include "rsf_cfg.svh"
module rsf_table import rsf_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire rsf_bus_t bus_i,
    input wire logic tbl_rd_i,
    input wire logic tbl_wr_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [21:0] tbl_ptr_o,
    output logic [7:0] tbl_lat_o,
    output logic mem_rd_o,
    output logic mem_wr_o
);
    logic [21:0] ptr_ff;
    logic [7:0] lat_ff;
    logic rd_ff;
    logic wr_ff;
    rsf_tbl_state_t state_ff;
    rsf_tbl_state_t nxt_state;
    wire logic start_rd = tbl_rd_i && state_ff == RSF_TBL_IDLE;
    wire logic start_wr = tbl_wr_i && !tbl_rd_i && state_ff == RSF_TBL_IDLE;
    wire logic wr_tpl = bus_i.wr && bus_i.addr == `RSF_A_TPL;
    wire logic wr_tph = bus_i.wr && bus_i.addr == `RSF_A_TPH;
    wire logic wr_tpu = bus_i.wr && bus_i.addr == `RSF_A_TPU;
    wire logic wr_lat = bus_i.wr && bus_i.addr == `RSF_A_TLAT;

    always_comb begin
        case (state_ff)
            RSF_TBL_IDLE: nxt_state = start_rd ? RSF_TBL_WAIT : RSF_TBL_IDLE;
            RSF_TBL_WAIT: nxt_state = RSF_TBL_IDLE;
            default: nxt_state = RSF_TBL_IDLE;
        endcase
    end

    // One byte per access: the pointer is a byte address, the latch the only data
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_ff <= `RSF_RST_TPTR;
            lat_ff <= `RSF_RST_BYTE;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            state_ff <= RSF_TBL_IDLE;
        end else begin
            state_ff <= nxt_state;
            rd_ff <= start_rd;
            wr_ff <= start_wr;
            if (wr_tpl) ptr_ff[7:0] <= bus_i.wdata;
            if (wr_tph) ptr_ff[15:8] <= bus_i.wdata;
            if (wr_tpu) ptr_ff[21:16] <= bus_i.wdata[5:0];
            if (state_ff == RSF_TBL_WAIT) begin
                lat_ff <= mem_rdata_i;
            end else if (wr_lat) begin
                lat_ff <= bus_i.wdata;
            end
        end
    end

    assign tbl_ptr_o = ptr_ff;
    assign tbl_lat_o = lat_ff;
    assign mem_rd_o = rd_ff;
    assign mem_wr_o = wr_ff;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_tbl_one_byte: assert property (mem_rd_o |=> !mem_rd_o && tbl_lat_o == $past(mem_rdata_i))
        else $error("table read did not move exactly one byte");
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb import rsf_pkg::*;;
    logic clock_i, rst_n_i, dev_rst_i, cfg_ovf_rst_en_i, push_i, vector_i, pop_i, fast_i;
    logic tbl_rd_i, tbl_wr_i, reg_wr_i, reg_rd_i, pop_valid_o, restore_o, stack_reset_o;
    logic mem_rd_o, mem_wr_o, irq_o;
    logic [20:0] push_addr_i, pop_addr_o;
    logic [7:0] mem_rdata_i, reg_wdata_i, reg_rdata_o, tbl_lat_o;
    logic [3:0] reg_addr_i;
    logic [21:0] tbl_ptr_o;
    rsf_ctx_t ctx_i, ctx_o;
    int err_total = 0;
    int checks = 0;
    localparam rsf_ctx_t C1 = 24'h112233;
    localparam rsf_ctx_t C2 = 24'hA55AC3;
    localparam rsf_ctx_t C3 = 24'h0FF081;

    rsf_stack #(.PC_W(21)) dut_u (
        .clock_i, .rst_n_i, .dev_rst_i, .cfg_ovf_rst_en_i, .push_i, .vector_i, .pop_i, .fast_i,
        .push_addr_i, .ctx_i, .tbl_rd_i, .tbl_wr_i, .mem_rdata_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pop_addr_o, .pop_valid_o, .ctx_o, .restore_o,
        .stack_reset_o, .tbl_ptr_o, .tbl_lat_o, .mem_rd_o, .mem_wr_o, .irq_o
    );
    rsf_core_model core_u (
        .clock_i, .mem_rd_i(mem_rd_o), .tbl_ptr_i(tbl_ptr_o), .push_o(push_i), .vector_o(vector_i),
        .pop_o(pop_i), .fast_o(fast_i), .push_addr_o(push_addr_i), .ctx_o(ctx_i),
        .mem_rdata_o(mem_rdata_i)
    );

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Counts: checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 check(reg_rdata_o, e);
    endtask

    task automatic t_regs();
        rchk(4'h0, 8'h00);
        rchk(4'h1, 8'h00);
        rchk(4'h2, 8'h00);
        wr(4'h0, 8'hFF);
        rchk(4'h0, 8'h1F);
        for (int a = 7; a < 16; a++) rchk(a[3:0], 8'h00);
        wr(4'h0, 8'h00);
    endtask

    task automatic t_order();
        core_u.op(1, 0, 0, 0, 21'h0ABC0, C1);
        core_u.op(1, 0, 0, 0, 21'h1D002, C1);
        rchk(4'h0, 8'h02);
        core_u.op(0, 0, 1, 0, 0, C1);
        check(pop_valid_o, 1'b1);
        check(pop_addr_o, 21'h1D002);
        core_u.op(0, 0, 1, 0, 0, C1);
        check(pop_addr_o, 21'h0ABC0);
        rchk(4'h0, 8'h00);
    endtask

    task automatic t_under();
        @(posedge clock_i);
        cfg_ovf_rst_en_i <= 1'b0;
        core_u.op(0, 0, 1, 0, 0, C1);
        check(pop_valid_o, 1'b1);
        check(pop_addr_o, 21'h0);
        check(stack_reset_o, 1'b0);
        rchk(4'h0, 8'h40);
        rchk(4'h1, 8'h02);
        check(irq_o, 1'b0);
        wr(4'h2, 8'h02);
        repeat (2) @(posedge clock_i);
        #1 check(irq_o, 1'b1);
        // Other resets must not touch the sticky flags
        @(posedge clock_i);
        dev_rst_i <= 1'b1;
        @(posedge clock_i);
        dev_rst_i <= 1'b0;
        rchk(4'h0, 8'h40);
        wr(4'h1, 8'h02);
        repeat (2) @(posedge clock_i);
        #1 check(irq_o, 1'b0);
        wr(4'h0, 8'h00);
        rchk(4'h0, 8'h00);
        @(posedge clock_i);
        cfg_ovf_rst_en_i <= 1'b1;
        core_u.op(0, 0, 1, 0, 0, C1);
        check(stack_reset_o, 1'b1);
        rchk(4'h0, 8'h40);
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h03);
        wr(4'h2, 8'h00);
    endtask

    task automatic t_full(input logic en);
        logic acc;
        acc = 1'b0;
        @(posedge clock_i);
        cfg_ovf_rst_en_i <= en;
        for (int i = 1; i <= 31; i++) begin
            core_u.op(1, 0, 0, 0, 21'h100 + 21'(2 * i), C1);
            if (i < 31) acc = acc | stack_reset_o;
        end
        check(acc, 1'b0);
        check(stack_reset_o, en);
        if (en) begin
            rchk(4'h0, 8'h80);
            wr(4'h0, 8'h9F);
            core_u.op(0, 0, 1, 0, 0, C1);
            check(pop_addr_o, 21'h13E);
            rchk(4'h0, 8'h9E);
        end else begin
            core_u.op(1, 0, 0, 0, 21'h1FFFE, C1);
            rchk(4'h0, 8'h9F);
            core_u.op(1, 0, 0, 0, 21'h1FFFC, C1);
            rchk(4'h0, 8'h9F);
            core_u.op(0, 0, 1, 0, 0, C1);
            check(pop_addr_o, 21'h13E);
        end
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h03);
        rchk(4'h0, 8'h00);
    endtask

    task automatic t_fast();
        @(posedge clock_i);
        cfg_ovf_rst_en_i <= 1'b0;
        core_u.op(0, 1, 0, 0, 21'h200, C1);
        core_u.op(0, 1, 0, 0, 21'h300, C2);
        core_u.op(0, 0, 1, 1, 0, C1);
        check(restore_o, 1'b1);
        check(ctx_o, C2);
        check(pop_addr_o, 21'h300);
        core_u.op(0, 0, 1, 0, 0, C1);
        check(restore_o, 1'b0);
        check(pop_addr_o, 21'h200);
        core_u.op(1, 0, 0, 1, 21'h400, C3);
        core_u.op(1, 0, 0, 0, 21'h402, C1);
        core_u.op(0, 0, 1, 0, 0, C1);
        core_u.op(0, 0, 1, 1, 0, C2);
        check(restore_o, 1'b1);
        check(ctx_o, C3);
        check(pop_addr_o, 21'h400);
        rchk(4'h0, 8'h00);
    endtask

    task automatic t_table();
        int n;
        wr(4'h3, 8'h34);
        wr(4'h4, 8'h12);
        wr(4'h5, 8'h3F);
        #1 check(tbl_ptr_o, 22'h3F1234);
        @(posedge clock_i);
        tbl_rd_i <= 1'b1;
        @(posedge clock_i);
        tbl_rd_i <= 1'b0;
        #1 n = 0;
        while (mem_rd_o !== 1'b1 && n < 4) begin
            @(posedge clock_i);
            #1 n++;
        end
        if (n == 4) begin
            err_total++;
            conclude();
        end
        @(posedge clock_i);
        #1 check(tbl_lat_o, 8'h91);
        rchk(4'h6, 8'h91);
        @(posedge clock_i);
        tbl_wr_i <= 1'b1;
        @(posedge clock_i);
        tbl_wr_i <= 1'b0;
        #1 check(mem_wr_o, 1'b1);
        check(tbl_lat_o, 8'h91);
    endtask

    initial begin
        rst_n_i = 1'b0;
        dev_rst_i = 1'b0;
        cfg_ovf_rst_en_i = 1'b0;
        tbl_rd_i = 1'b0;
        tbl_wr_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_order();
        t_under();
        t_full(1'b0);
        t_full(1'b1);
        t_fast();
        t_table();
        conclude();
    end

    // Hang guard: far above the longest legal run
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        conclude();
    end
endmodule
